// ---- rtl/spi_cfg_pkg.sv ----
package spi_cfg_pkg;
  // Register byte addresses (one aligned word each)
  localparam logic [4:0] ctl1_addr = 5'h00;
  localparam logic [4:0] ctl2_addr = 5'h04;
  localparam logic [4:0] baud_addr = 5'h08;
  localparam logic [4:0] stat_addr = 5'h0c;
  localparam logic [4:0] match_addr = 5'h10;
  localparam logic [4:0] data_addr = 5'h14;
  // Control one fields
  localparam int c1_rx_irq = 7;
  localparam int c1_enable = 6;
  localparam int c1_tx_irq = 5;
  localparam int c1_master = 4;
  localparam int c1_clock_polarity = 3;
  localparam int c1_cpha = 2;
  localparam int c1_select_output_enable = 1;
  localparam int c1_lsb = 0;
  // Control two fields
  localparam int c2_match_irq = 7;
  localparam int c2_fault_en = 4;
  localparam int c2_bidir_oe = 3;
  localparam int c2_wait_stop = 1;
  localparam int c2_single_pin = 0;
  localparam logic [7:0] c2_mask = 8'h9b;
  localparam logic [7:0] baud_mask = 8'h77;
  // Status fields
  localparam int s_rx_full = 7;
  localparam int s_match = 6;
  localparam int s_tx_empty = 5;
  localparam int s_fault = 4;
  // Reset values
  localparam logic [7:0] ctl1_rst = 8'h04;
  localparam logic [7:0] ctl2_rst = 8'h00;
  localparam logic [7:0] baud_rst = 8'h00;
  localparam logic [7:0] match_rst = 8'h00;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0] {st_idle, st_lead, st_trail} xfer_state_t;
endpackage : spi_cfg_pkg

// ---- rtl/spi_config_and_status.sv ----
// Functional notes
// - Control one bit 7 enables receive-full and fault interrupt requests.
// - Control one bit 6 enables the whole serial interface.
// - Control one bit 5 enables the transmit-empty interrupt request.
// - Control one bit 4 makes the interface master, generating serial clock.
// - Control one bit 3 selects clock polarity; 0 means idle low.
// - Control one bit 2 selects phase; 1 puts first edge at cycle start.
// - Control one bit 1 sets slave-select pin function with fault detection.
// - Control one bit 0 selects bit order; 0 sends MSB first.
// - Control two bit 7 enables the match interrupt request.
// - Control two bit 4 enables mode-fault detection.
// - Control two bit 3 drives shared data pin in bidirectional mode.
// - Control two bit 1 stops clocks in wait mode when set.
// - Control two bit 0 selects single shared data pin when set.
// - Baud bits 6:4 set prescale divisor, 000 means one; bit 7 reserved.
// - Baud bits 2:0 set rate divisor, 000 means two; bit 3 reserved.
// - Smallest settings give serial clock at bus clock divided by two.
// - Status bit 7 sets when receive buffer fills.
// - Status bit 6 sets when match register equals receive buffer.
// - Status bit 5 sets when transmit buffer is empty.
// - Status bit 4 is master fault flag; bits 3:0 reserved.
// - Match register holds an 8-bit value compared with receive buffer.
// - Data register write loads transmit buffer, read returns receive buffer.
// - Mode fault aborts transfer and clears master select.
// - Interrupt request raised while the interface is enabled and any flag and its enable are set.
`timescale 1ns/100ps
module spi_config_and_status (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Low-power input
  input wire logic wait_mode,
  // Serial pins
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic ss_n_oe,
  // Interrupt request
  output logic irq
);
  logic [7:0] ctl1_ff, ctl2_ff, baud_ff, match_ff, tx_buf_ff, rx_buf_ff, shift_ff;
  logic rx_full_ff, match_ff_flag, tx_empty_ff, fault_ff, tx_loaded_ff;
  logic [3:0] bit_cnt_ff;
  logic [2:0] sck_sync_ff, ss_sync_ff, mosi_sync_ff, miso_sync_ff;
  spi_cfg_pkg::xfer_state_t state_ff;
  logic half_tick, run_master, sclk_ff, ssel_ff, end_xfer, fault_evt;
  logic sck_s, ss_s, din_s, slave_edge_lead, slave_edge_trail, slave_active;
  logic aw_ok_ff, w_ok_ff;
  logic [4:0] aw_addr_ff;
  logic [7:0] wbyte_ff;
  logic do_write, do_read, rd_data_sel, rd_status;
  logic [7:0] rdata_sel;
  logic cfg_en, cfg_master_select, cfg_clock_polarity, cfg_cpha, cfg_lsb, cfg_single;
  logic sample_bit;
  logic out_bit_ff;

  assign cfg_en = ctl1_ff[spi_cfg_pkg::c1_enable];
  assign cfg_master_select = ctl1_ff[spi_cfg_pkg::c1_master];
  assign cfg_clock_polarity = ctl1_ff[spi_cfg_pkg::c1_clock_polarity];
  assign cfg_cpha = ctl1_ff[spi_cfg_pkg::c1_cpha];
  assign cfg_lsb = ctl1_ff[spi_cfg_pkg::c1_lsb];
  assign cfg_single = ctl2_ff[spi_cfg_pkg::c2_single_pin];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: only stage two and later are read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_sync_ff <= 3'h0;
      ss_sync_ff <= 3'h7;
      mosi_sync_ff <= 3'h0;
      miso_sync_ff <= 3'h0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[1:0], serial_clock_pin_in};
      ss_sync_ff <= {ss_sync_ff[1:0], ss_n_in};
      mosi_sync_ff <= {mosi_sync_ff[1:0], mosi_in};
      miso_sync_ff <= {miso_sync_ff[1:0], miso_in};
    end
  end
  assign sck_s = sck_sync_ff[1];
  assign ss_s = ss_sync_ff[1];
  // Master listens on miso, slave on mosi; in single-pin mode the master also listens on mosi
  assign din_s = (cfg_master_select && !cfg_single) ? miso_sync_ff[1] : mosi_sync_ff[1];
  // Edge parity: leading edge is rising when clock_polarity is 0
  assign slave_edge_lead = (sck_sync_ff[2] ^ cfg_clock_polarity) == 1'b0 && (sck_s ^ cfg_clock_polarity);
  assign slave_edge_trail = (sck_sync_ff[2] ^ cfg_clock_polarity) && (sck_s ^ cfg_clock_polarity) == 1'b0;
  assign slave_active = cfg_en && !cfg_master_select && !ss_s;

  //////////////////////////////////////////////////////////////////////////////
  // Rate generator; wait-mode stop freezes the master clock
  assign run_master = cfg_en && cfg_master_select && state_ff != spi_cfg_pkg::st_idle
                      && !(wait_mode && ctl2_ff[spi_cfg_pkg::c2_wait_stop]);
  spi_rate_gen u_rate (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_master),
    .prescale(baud_ff[6:4]),
    .rate(baud_ff[3:0]),
    .half_tick(half_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Mode fault: master sees slave-select low while fault detect and ss input in use
  assign fault_evt = cfg_en && cfg_master_select && ctl2_ff[spi_cfg_pkg::c2_fault_en]
                     && !ctl1_ff[spi_cfg_pkg::c1_select_output_enable] && !ss_s;

  //////////////////////////////////////////////////////////////////////////////
  // Transfer engine
  assign sample_bit = cfg_lsb ? shift_ff[0] : shift_ff[7];
  assign end_xfer = (state_ff == spi_cfg_pkg::st_trail) && (bit_cnt_ff == 4'h7)
                    && (cfg_master_select ? half_tick : slave_edge_trail);

  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg_en || fault_evt) begin
      state_ff <= spi_cfg_pkg::st_idle;
      bit_cnt_ff <= 4'h0;
      sclk_ff <= 1'b0;
      ssel_ff <= 1'b1;
      shift_ff <= 8'h00;
      tx_loaded_ff <= 1'b0;
    end else begin
      if (do_write && aw_addr_ff == spi_cfg_pkg::data_addr) begin
        tx_loaded_ff <= 1'b1;
      end
      case (state_ff)
        spi_cfg_pkg::st_idle: begin
          sclk_ff <= 1'b0;
          bit_cnt_ff <= 4'h0;
          if (cfg_master_select && tx_loaded_ff) begin
            shift_ff <= tx_buf_ff;
            tx_loaded_ff <= 1'b0;
            ssel_ff <= 1'b0;
            state_ff <= spi_cfg_pkg::st_lead;
          end else if (!cfg_master_select && slave_active) begin
            shift_ff <= tx_buf_ff;
            tx_loaded_ff <= 1'b0;
            state_ff <= spi_cfg_pkg::st_lead;
          end else begin
            ssel_ff <= 1'b1;
          end
        end
        spi_cfg_pkg::st_lead: begin
          if (cfg_master_select ? half_tick : slave_edge_lead) begin
            // Phase 1 toggles at bit start; phase 0 samples here
            sclk_ff <= 1'b1;
            if (!cfg_cpha) begin
              shift_ff <= cfg_lsb ? {din_s, shift_ff[7:1]} : {shift_ff[6:0], din_s};
            end
            state_ff <= spi_cfg_pkg::st_trail;
          end else if (!cfg_master_select && ss_s) begin
            state_ff <= spi_cfg_pkg::st_idle;
          end
        end
        spi_cfg_pkg::st_trail: begin
          if (cfg_master_select ? half_tick : slave_edge_trail) begin
            sclk_ff <= 1'b0;
            if (cfg_cpha) begin
              shift_ff <= cfg_lsb ? {din_s, shift_ff[7:1]} : {shift_ff[6:0], din_s};
            end
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            state_ff <= (bit_cnt_ff == 4'h7) ? spi_cfg_pkg::st_idle : spi_cfg_pkg::st_lead;
          end else if (!cfg_master_select && ss_s) begin
            // Deselect mid-bit must not leave the clock level high in idle
            sclk_ff <= 1'b0;
            state_ff <= spi_cfg_pkg::st_idle;
          end
        end
        default: state_ff <= spi_cfg_pkg::st_idle;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      ss_n_out <= 1'b1;
      ss_n_oe <= 1'b0;
      out_bit_ff <= 1'b0;
    end else begin
      serial_clock_pin_out <= sclk_ff ^ cfg_clock_polarity;
      serial_clock_pin_oe <= cfg_en && cfg_master_select;
      // Data lags the clock pin by one bus clock, giving hold time at the capture edge
      out_bit_ff <= sample_bit;
      mosi_out <= out_bit_ff;
      miso_out <= out_bit_ff;
      // Single-pin mode: master uses mosi, slave uses miso, direction from bidir bit
      if (cfg_single) begin
        mosi_oe <= cfg_en && cfg_master_select && ctl2_ff[spi_cfg_pkg::c2_bidir_oe];
        miso_oe <= cfg_en && !cfg_master_select && !ss_s && ctl2_ff[spi_cfg_pkg::c2_bidir_oe];
      end else begin
        mosi_oe <= cfg_en && cfg_master_select;
        miso_oe <= cfg_en && !cfg_master_select && !ss_s;
      end
      ss_n_out <= ssel_ff;
      ss_n_oe <= cfg_en && cfg_master_select && ctl2_ff[spi_cfg_pkg::c2_fault_en]
                 && ctl1_ff[spi_cfg_pkg::c1_select_output_enable];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags; hardware set beats a clearing access in the same cycle, except transmit-empty, where a data write wins
  assign rd_status = do_read && s_axi_araddr == spi_cfg_pkg::stat_addr;
  assign rd_data_sel = do_read && s_axi_araddr == spi_cfg_pkg::data_addr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_ff <= 8'h00;
      rx_full_ff <= 1'b0;
      match_ff_flag <= 1'b0;
    end else if (end_xfer && !rx_full_ff) begin
      // Unserviced receive-full drops the new byte
      rx_buf_ff <= cfg_cpha ? (cfg_lsb ? {din_s, shift_ff[7:1]} : {shift_ff[6:0], din_s})
                            : shift_ff;
      rx_full_ff <= 1'b1;
      match_ff_flag <= ((cfg_cpha ? (cfg_lsb ? {din_s, shift_ff[7:1]}
                         : {shift_ff[6:0], din_s}) : shift_ff) == match_ff);
    end else begin
      if (rd_data_sel) begin
        rx_full_ff <= 1'b0;
      end
      if (do_write && aw_addr_ff == spi_cfg_pkg::stat_addr
          && wbyte_ff[spi_cfg_pkg::s_match]) begin
        match_ff_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_ff <= 1'b1;
      tx_buf_ff <= 8'h00;
    end else if (do_write && aw_addr_ff == spi_cfg_pkg::data_addr) begin
      tx_buf_ff <= wbyte_ff;
      tx_empty_ff <= 1'b0;
    end else if (!tx_loaded_ff || !cfg_en) begin
      tx_empty_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_ff <= 1'b0;
    end else if (fault_evt) begin
      fault_ff <= 1'b1;
    end else if (do_write && aw_addr_ff == spi_cfg_pkg::ctl1_addr) begin
      fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= cfg_en && ((ctl1_ff[spi_cfg_pkg::c1_rx_irq] && (rx_full_ff || fault_ff))
             || (ctl1_ff[spi_cfg_pkg::c1_tx_irq] && tx_empty_ff)
             || (ctl2_ff[spi_cfg_pkg::c2_match_irq] && match_ff_flag));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: capture address and data in either order
  assign do_write = aw_ok_ff && w_ok_ff && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_addr_ff <= 5'h00;
      wbyte_ff <= 8'h00;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spi_cfg_pkg::resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wbyte_ff <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_ff[1:0] == 2'h0 && aw_addr_ff <= spi_cfg_pkg::data_addr)
                       ? spi_cfg_pkg::resp_okay : spi_cfg_pkg::resp_slverr;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Byte lane 0 only; a write without it stores zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl1_ff <= spi_cfg_pkg::ctl1_rst;
      ctl2_ff <= spi_cfg_pkg::ctl2_rst;
      baud_ff <= spi_cfg_pkg::baud_rst;
      match_ff <= spi_cfg_pkg::match_rst;
    end else if (fault_evt) begin
      ctl1_ff[spi_cfg_pkg::c1_master] <= 1'b0;
    end else if (do_write) begin
      case (aw_addr_ff)
        spi_cfg_pkg::ctl1_addr: ctl1_ff <= wbyte_ff;
        spi_cfg_pkg::ctl2_addr: ctl2_ff <= wbyte_ff & spi_cfg_pkg::c2_mask;
        spi_cfg_pkg::baud_addr: baud_ff <= wbyte_ff & spi_cfg_pkg::baud_mask;
        spi_cfg_pkg::match_addr: match_ff <= wbyte_ff;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one cycle to answer
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_comb begin
    case (s_axi_araddr)
      spi_cfg_pkg::ctl1_addr: rdata_sel = ctl1_ff;
      spi_cfg_pkg::ctl2_addr: rdata_sel = ctl2_ff;
      spi_cfg_pkg::baud_addr: rdata_sel = baud_ff;
      spi_cfg_pkg::stat_addr: rdata_sel = {rx_full_ff, match_ff_flag, tx_empty_ff,
                                           fault_ff, 4'h0};
      spi_cfg_pkg::match_addr: rdata_sel = match_ff;
      spi_cfg_pkg::data_addr: rdata_sel = rx_buf_ff;
      default: rdata_sel = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= spi_cfg_pkg::resp_okay;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rdata_sel};
      s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= spi_cfg_pkg::data_addr)
                     ? spi_cfg_pkg::resp_okay : spi_cfg_pkg::resp_slverr;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  fault_clears_master_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_evt |=> !ctl1_ff[spi_cfg_pkg::c1_master] && fault_ff)
    else $error("fault did not clear master select");
  fault_aborts_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_evt |=> state_ff == spi_cfg_pkg::st_idle)
    else $error("fault did not abort transfer");
  irq_tx_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_en && ctl1_ff[spi_cfg_pkg::c1_tx_irq] && tx_empty_ff |=> irq)
    else $error("transmit empty interrupt missing");
  irq_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_en |=> !irq)
    else $error("interrupt while disabled");
  rx_full_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    end_xfer && !rx_full_ff |=> rx_full_ff)
    else $error("receive full not set");
  sck_pol_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == spi_cfg_pkg::st_idle && $stable(cfg_clock_polarity) |=>
      serial_clock_pin_out == $past(cfg_clock_polarity))
    else $error("idle clock level wrong");
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (baud_ff[7] == 1'b0) && (ctl2_ff & ~spi_cfg_pkg::c2_mask) == 8'h00)
    else $error("reserved bit set");
  data_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr_ff == spi_cfg_pkg::data_addr |=> !tx_empty_ff && tx_buf_ff == $past(wbyte_ff))
    else $error("data write not buffered");
endmodule : spi_config_and_status

// ---- rtl/spi_rate_gen.sv ----
`timescale 1ns/100ps
// Half-period tick: period = (prescale+1) * 2^(rate+1) bus clocks per serial clock
module spi_rate_gen (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [2:0] prescale,
  input wire logic [3:0] rate,
  // Half-period enable
  output logic half_tick
);
  logic [2:0] pre_ff;
  logic [15:0] div_ff;
  logic [15:0] half_lim;
  logic pre_done;

  assign pre_done = (pre_ff == prescale);
  assign half_lim = 16'((17'h1 << rate) - 17'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      pre_ff <= 3'h0;
    end else if (pre_done) begin
      pre_ff <= 3'h0;
    end else begin
      pre_ff <= pre_ff + 3'h1;
    end
  end

  // Smallest setting ticks every bus clock: serial clock = bus clock / 2
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_ff <= 16'h0;
      half_tick <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      if (pre_done) begin
        if (div_ff == half_lim) begin
          div_ff <= 16'h0;
          half_tick <= 1'b1;
        end else begin
          div_ff <= div_ff + 16'h1;
        end
      end
    end
  end
endmodule : spi_rate_gen

// ---- tb/spi_far_device.sv ----
`timescale 1ns/100ps
module spi_far_device (
  // Serial side
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel,
  input wire logic clock_polarity,
  // Bench side
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  logic [2:0] cnt;
  logic last;
  wire logic lead = sclk ^ clock_polarity;
  initial begin
    sh = 8'h00;
    cnt = 3'h0;
    last = 1'b0;
    rx_byte = 8'h00;
  end
  always @(posedge sel) begin
    sh = tx_byte;
    cnt = 3'h0;
  end
  // Phase one: drive on the leading edge, capture on the trailing one
  always @(posedge lead) if (sel) last = sh[7];
  always @(negedge lead) begin
    if (sel) begin
      sh = {sh[6:0], mosi};
      cnt = cnt + 3'h1;
      if (cnt == 3'h0) begin
        rx_byte = sh;
        sh = tx_byte;
      end
    end
  end
  // A released line must not keep its last bit, or a stale sample could pass
  assign miso = sel ? last : ~last;
endmodule : spi_far_device

// ---- tb/tb_spi_config_and_status.sv ----
`timescale 1ns/100ps
module tb_spi_config_and_status;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic ss_n = 1'b1, sel = 1'b0, clock_polarity_m = 1'b0;
  logic [7:0] tx_b = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, irq, far_miso, prev_sck;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic [7:0] far_rx;
  int failures = 0, comparisons = 0, since = 0, period = 0;
  wire logic sck = sck_oe ? sck_o : 1'b0;
  wire logic mosi = mosi_oe ? mosi_o : 1'b1;
  wire logic miso = miso_oe ? miso_o : far_miso;
  always #4 aclk = ~aclk;
  spi_config_and_status dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_mode(1'b0),
    .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
    .mosi_in(mosi), .mosi_out(mosi_o), .mosi_oe(mosi_oe), .miso_in(miso),
    .miso_out(miso_o), .miso_oe(miso_oe), .ss_n_in(ss_n), .ss_n_out(ss_o), .ss_n_oe(ss_oe),
    .irq(irq));
  spi_far_device far (.sclk(sck), .mosi(mosi), .sel(sel), .clock_polarity(clock_polarity_m), .tx_byte(tx_b),
    .miso(far_miso), .rx_byte(far_rx));
  // Bus clocks between rising serial clock edges
  always @(posedge aclk) begin
    prev_sck <= sck_o;
    since <= since + 1;
    if (sck_o && !prev_sck) begin
      period <= since + 1;
      since <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        check("bresp", er, bresp);
        return;
      end
    end
    failures++;
    test_done();
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        check("rresp", er, rresp);
        check("rdata", {24'h0, ed}, rdata);
        return;
      end
    end
    failures++;
    test_done();
  endtask : rd
  task automatic wait_rx();
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 4000; n++) begin
      @(posedge aclk);
      if (since < 2) seen = 1'b1;
      if (seen && since > 40 && arready === 1'b1) return;
    end
    failures++;
    test_done();
  endtask : wait_rx
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(spi_cfg_pkg::ctl1_addr, 8'h04, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::ctl2_addr, 8'h00, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::baud_addr, 8'h00, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::stat_addr, 8'h20, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::match_addr, 8'h00, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::data_addr, 8'h00, spi_cfg_pkg::resp_okay);
    rd(5'h18, 8'h00, spi_cfg_pkg::resp_slverr);
    wr(5'h18, 8'hff, spi_cfg_pkg::resp_slverr);
    wr(spi_cfg_pkg::ctl2_addr, 8'hff, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::ctl2_addr, 8'h9b, spi_cfg_pkg::resp_okay);
    wr(spi_cfg_pkg::baud_addr, 8'hff, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::baud_addr, 8'h77, spi_cfg_pkg::resp_okay);
    wr(spi_cfg_pkg::ctl2_addr, 8'h00, spi_cfg_pkg::resp_okay);
    wr(spi_cfg_pkg::baud_addr, 8'h00, spi_cfg_pkg::resp_okay);
  endtask : t_reset
  task automatic xfer(input logic [7:0] c1, input logic [7:0] d, input logic [7:0] far_d);
    wr(spi_cfg_pkg::ctl1_addr, c1, spi_cfg_pkg::resp_okay);
    tx_b <= far_d;
    sel <= 1'b1;
    wr(spi_cfg_pkg::data_addr, d, spi_cfg_pkg::resp_okay);
    wait_rx();
    sel <= 1'b0;
  endtask : xfer
  task automatic t_fast();
    // Far side sends zero, so the received byte equals the reset match value
    xfer(8'h54, 8'ha5, 8'h00);
    check("period", 32'd2, period);
    check("far rx", 32'h00a5, {24'h0, far_rx});
    rd(spi_cfg_pkg::stat_addr, 8'he0, spi_cfg_pkg::resp_okay);
  endtask : t_fast
  task automatic t_match();
    wr(spi_cfg_pkg::baud_addr, 8'h02, spi_cfg_pkg::resp_okay);
    wr(spi_cfg_pkg::match_addr, 8'h3c, spi_cfg_pkg::resp_okay);
    wr(spi_cfg_pkg::ctl2_addr, 8'h80, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::data_addr, 8'h00, spi_cfg_pkg::resp_okay);
    xfer(8'h54, 8'h5a, 8'h3c);
    check("period", 32'd8, period);
    check("far rx", 32'h005a, {24'h0, far_rx});
    rd(spi_cfg_pkg::stat_addr, 8'he0, spi_cfg_pkg::resp_okay);
    check("irq", 32'h1, {31'h0, irq});
    rd(spi_cfg_pkg::data_addr, 8'h3c, spi_cfg_pkg::resp_okay);
    wr(spi_cfg_pkg::stat_addr, 8'h40, spi_cfg_pkg::resp_okay);
    repeat (3) @(posedge aclk);
    check("irq", 32'h0, {31'h0, irq});
    xfer(8'h55, 8'h01, 8'h00);
    check("far rx", 32'h0080, {24'h0, far_rx});
    rd(spi_cfg_pkg::data_addr, 8'h00, spi_cfg_pkg::resp_okay);
  endtask : t_match
  task automatic t_fault();
    wr(spi_cfg_pkg::ctl2_addr, 8'h10, spi_cfg_pkg::resp_okay);
    wr(spi_cfg_pkg::ctl1_addr, 8'hd4, spi_cfg_pkg::resp_okay);
    ss_n <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(spi_cfg_pkg::stat_addr, 8'h30, spi_cfg_pkg::resp_okay);
    rd(spi_cfg_pkg::ctl1_addr, 8'hc4, spi_cfg_pkg::resp_okay);
    check("irq", 32'h1, {31'h0, irq});
    ss_n <= 1'b1;
    wr(spi_cfg_pkg::ctl1_addr, 8'h5c, spi_cfg_pkg::resp_okay);
    clock_polarity_m <= 1'b1;
    repeat (4) @(posedge aclk);
    check("sck idle", 32'h3, {30'h0, sck_oe, sck_o});
    wr(spi_cfg_pkg::ctl1_addr, 8'h7c, spi_cfg_pkg::resp_okay);
    repeat (3) @(posedge aclk);
    check("irq", 32'h1, {31'h0, irq});
    wr(spi_cfg_pkg::ctl1_addr, 8'h00, spi_cfg_pkg::resp_okay);
    repeat (4) @(posedge aclk);
    check("sck oe", 32'h0, {31'h0, sck_oe});
    check("irq", 32'h0, {31'h0, irq});
    rd(spi_cfg_pkg::stat_addr, 8'h20, spi_cfg_pkg::resp_okay);
  endtask : t_fault
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fast();
    t_match();
    t_fault();
    test_done();
  end
endmodule : tb_spi_config_and_status
